// >>> include/jtdr_pkg.sv
// package for the test data registers behind the test access port
// assumes the instruction register is five bits wide
package jtdr_pkg;
   // ----------------------------------------------------------------
   // instruction codes
   // ----------------------------------------------------------------
   localparam int          IR_WIDTH      = 5;
   localparam logic [4:0]  INSN_EXTEST   = 5'h00;
   localparam logic [4:0]  INSN_SAMPLE   = 5'h01;
   localparam logic [4:0]  INSN_IDCODE   = 5'h0C;
   localparam logic [4:0]  INSN_BYPASS   = 5'h1F;
   localparam logic [4:0]  IR_CAPTURE    = 5'h01;
   // ----------------------------------------------------------------
   // identification word layout
   // ----------------------------------------------------------------
   localparam int          ID_VER_LSB    = 28;
   localparam int          ID_PART_LSB   = 12;
   localparam int          ID_MFR_LSB    = 1;
   localparam logic        ID_FIXED_BIT  = 1'b1;
   // ----------------------------------------------------------------
   // tap states
   // ----------------------------------------------------------------
   typedef enum logic [3:0]
   {
      TAP_RESET      = 4'h0,
      TAP_IDLE       = 4'h1,
      TAP_SEL_DR     = 4'h2,
      TAP_CAP_DR     = 4'h3,
      TAP_SHIFT_DR   = 4'h4,
      TAP_EXIT1_DR   = 4'h5,
      TAP_PAUSE_DR   = 4'h6,
      TAP_EXIT2_DR   = 4'h7,
      TAP_UPD_DR     = 4'h8,
      TAP_SEL_IR     = 4'h9,
      TAP_CAP_IR     = 4'hA,
      TAP_SHIFT_IR   = 4'hB,
      TAP_EXIT1_IR   = 4'hC,
      TAP_PAUSE_IR   = 4'hD,
      TAP_EXIT2_IR   = 4'hE,
      TAP_UPD_IR     = 4'hF
   } jtdr_state_t;
endpackage

// >>> logic/jtdr_top.sv
// tap controller, instruction register and test data registers
// assumes tck from the tester; rst_n is the power-on reset in core_clk
`timescale 1ns/1ns
`default_nettype none
module jtdr_top
   import jtdr_pkg::*;
#(
   parameter int         N_IN     = 4,
   parameter int         N_OUT    = 4,
   parameter int         N_OE     = 2,
   parameter int         N_BIDIR  = 2,
   parameter logic [3:0]  ID_VER  = 4'h6,   // arbitrary value
   parameter logic [15:0] ID_PART = 16'h1234, // arbitrary value
   parameter logic [10:0] ID_MFR  = 11'h055  // arbitrary value
)
(
   // core clock and power-on reset
   input  wire logic               core_clk,
   input  wire logic               rst_n,
   // test access port
   input  wire logic               tck,
   input  wire logic               tms,
   input  wire logic               tdi,
   output logic                    tdo,
   output logic                    tdo_oe,
   // system pin values observed by the chain
   input  wire logic [N_IN-1:0]    pin_in,
   input  wire logic [N_OUT-1:0]   drv_out,
   input  wire logic [N_OE-1:0]    drv_oe,
   input  wire logic [N_BIDIR-1:0] bidir_in
);
   // ----------------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------------
   localparam int BSR_LEN = N_IN + N_OUT + N_OE + N_BIDIR;
   if (N_IN < 1 || N_OUT < 1 || N_OE < 1 || N_BIDIR < 1)
   begin : g_bad_cells
      $error("each boundary cell type needs at least one cell");
   end

   // ----------------------------------------------------------------
   // power-on reset carried into the tck domain
   // ----------------------------------------------------------------
   // a level crossing: rst_n is taken on core_clk, then two tck flops;
   // tck may stop, so reset reaches the tap only once tck runs again
   // and it must see at least three tck edges while rst_n is low
   logic       por_q;
   logic       por_s1_q;
   logic       por_s2_q;
   logic       tap_rst;
   always_ff @(posedge core_clk)
      por_q <= ~rst_n;
   always_ff @(posedge tck)
   begin
      por_s1_q <= por_q;
      por_s2_q <= por_s1_q;
   end
   assign tap_rst = por_s2_q;

   // ----------------------------------------------------------------
   // tap state machine
   // ----------------------------------------------------------------
   jtdr_state_t st_q;
   jtdr_state_t st_d;
   always_comb
   begin
      case (st_q)
         TAP_RESET:    st_d = tms ? TAP_RESET    : TAP_IDLE;
         TAP_IDLE:     st_d = tms ? TAP_SEL_DR   : TAP_IDLE;
         TAP_SEL_DR:   st_d = tms ? TAP_SEL_IR   : TAP_CAP_DR;
         TAP_CAP_DR:   st_d = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
         TAP_SHIFT_DR: st_d = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
         TAP_EXIT1_DR: st_d = tms ? TAP_UPD_DR   : TAP_PAUSE_DR;
         TAP_PAUSE_DR: st_d = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
         TAP_EXIT2_DR: st_d = tms ? TAP_UPD_DR   : TAP_SHIFT_DR;
         TAP_UPD_DR:   st_d = tms ? TAP_SEL_DR   : TAP_IDLE;
         TAP_SEL_IR:   st_d = tms ? TAP_RESET    : TAP_CAP_IR;
         TAP_CAP_IR:   st_d = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
         TAP_SHIFT_IR: st_d = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
         TAP_EXIT1_IR: st_d = tms ? TAP_UPD_IR   : TAP_PAUSE_IR;
         TAP_PAUSE_IR: st_d = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
         TAP_EXIT2_IR: st_d = tms ? TAP_UPD_IR   : TAP_SHIFT_IR;
         TAP_UPD_IR:   st_d = tms ? TAP_SEL_DR   : TAP_IDLE;
         default:      st_d = TAP_RESET;
      endcase
   end

   // power-on reset wins over tms
   always_ff @(posedge tck)
   begin
      if (tap_rst)
         st_q <= TAP_RESET;
      else
         st_q <= st_d;
   end

   // ----------------------------------------------------------------
   // instruction register
   // ----------------------------------------------------------------
   logic [IR_WIDTH-1:0] ir_sh_q;
   logic [IR_WIDTH-1:0] ir_q;
   always_ff @(posedge tck)
   begin
      if (tap_rst || st_q == TAP_RESET)
         ir_sh_q <= INSN_BYPASS;
      else if (st_q == TAP_CAP_IR)
         ir_sh_q <= IR_CAPTURE;             // fixed 01 capture pattern
      else if (st_q == TAP_SHIFT_IR)
         ir_sh_q <= {tdi, ir_sh_q[IR_WIDTH-1:1]};
   end

   always_ff @(posedge tck)
   begin
      if (tap_rst || st_q == TAP_RESET)
         ir_q <= INSN_IDCODE;                 // id selected out of reset
      else if (st_q == TAP_UPD_IR)
         ir_q <= ir_sh_q;
   end

   // decode: anything not listed falls to bypass
   logic sel_id;
   logic sel_bsr;
   logic sel_byp;
   assign sel_id  = (ir_q == INSN_IDCODE);
   assign sel_bsr = (ir_q == INSN_EXTEST) || (ir_q == INSN_SAMPLE);
   assign sel_byp = ~sel_id & ~sel_bsr;

   // ----------------------------------------------------------------
   // bypass stage
   // ----------------------------------------------------------------
   logic byp_q;
   always_ff @(posedge tck)
   begin
      if (st_q == TAP_CAP_DR)
         byp_q <= 1'b0;
      else if (st_q == TAP_SHIFT_DR)
         byp_q <= tdi;
   end

   // ----------------------------------------------------------------
   // identification word
   // ----------------------------------------------------------------
   logic [31:0] id_word;
   logic [31:0] id_sh_q;
   assign id_word = {ID_VER, ID_PART, ID_MFR, ID_FIXED_BIT};
   always_ff @(posedge tck)
   begin
      if (st_q == TAP_CAP_DR && sel_id)
         id_sh_q <= id_word;
      else if (st_q == TAP_SHIFT_DR && sel_id)
         id_sh_q <= {tdi, id_sh_q[31:1]};
   end

   // ----------------------------------------------------------------
   // boundary chain
   // ----------------------------------------------------------------
   // cell order: input cells, output cells, enable cells, bidir cells;
   // each type observes its own pin function, and the chain only
   // observes, so the system path is left untouched
   logic [BSR_LEN-1:0] pin_raw;
   logic [BSR_LEN-1:0] pin_s1_q;
   logic [BSR_LEN-1:0] pin_s2_q;
   logic [BSR_LEN-1:0] pin_s3_q;
   logic [BSR_LEN-1:0] pin_agree;
   logic [BSR_LEN-1:0] pin_q;
   logic [BSR_LEN-1:0] bsr_cap;
   logic [BSR_LEN-1:0] bsr_q;
   assign pin_raw = {bidir_in, drv_oe, drv_out, pin_in};

   // pins are asynchronous to tck: three stages, and a bit is only
   // taken once the last two agree, so a capture sees no metastable
   // level; the price is that a pin must be steady for two tck edges
   always_ff @(posedge tck)
   begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
   end
   assign pin_agree = ~(pin_s2_q ^ pin_s3_q);
   always_ff @(posedge tck)
      pin_q <= (pin_q & ~pin_agree) | (pin_s3_q & pin_agree);
   assign bsr_cap = pin_q;
   always_ff @(posedge tck)
   begin
      if (st_q == TAP_CAP_DR && sel_bsr)
         bsr_q <= bsr_cap;
      else if (st_q == TAP_SHIFT_DR && sel_bsr)
         bsr_q <= {tdi, bsr_q[BSR_LEN-1:1]};
   end

   // ----------------------------------------------------------------
   // tdo, changed on the falling edge
   // ----------------------------------------------------------------
   logic tdo_mux;
   assign tdo_mux = (st_q == TAP_SHIFT_IR) ? ir_sh_q[0] :
                    sel_byp ? byp_q      :
                    sel_id  ? id_sh_q[0] : bsr_q[0];
   logic tdo_q;
   logic tdo_oe_q;
   always_ff @(negedge tck)
   begin
      if (tap_rst)
      begin
         tdo_q    <= 1'b0;
         tdo_oe_q <= 1'b0;
      end
      else
      begin
         tdo_q    <= tdo_mux;
         tdo_oe_q <= (st_q == TAP_SHIFT_DR) || (st_q == TAP_SHIFT_IR);
      end
   end
   assign tdo    = tdo_q;
   assign tdo_oe = tdo_oe_q;
endmodule
`default_nettype wire

// >>> testbench/jtdr_checker.sv
// assertions on the tap pins of the top module
// assumes tms moves just after falling tck, as a tester does
`timescale 1ns/1ns
`default_nettype none
module jtdr_checker
(
   // tap pins and power-on reset
   input wire logic rst_n,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdo,
   input wire logic tdo_oe
);
   // ----------------------------------------------------------------
   // falling tck sees tms as the last rising edge took it
   // ----------------------------------------------------------------
   default clocking cb @(negedge tck);
   endclocking
   a_rst_tdo_low: assert property (!rst_n [*4] |-> !tdo)
      else $error("tdo high in reset");
   a_rst_oe_low: assert property (!rst_n [*4] |-> !tdo_oe)
      else $error("tdo_oe high in reset");
   a_shift_entry: assert property (disable iff (!rst_n)
      $rose(tdo_oe) |-> !$past(tms)) else $error("shift entered early");
   a_select_first: assert property (disable iff (!rst_n)
      $rose(tdo_oe) |-> $past(tms, 2) || $past(tms, 3))
      else $error("shift without select");
   a_shift_hold: assert property (disable iff (!rst_n)
      tdo_oe && !tms |=> tdo_oe) else $error("shift dropped");
   a_shift_exit: assert property (disable iff (!rst_n)
      $fell(tdo_oe) |-> $past(tms)) else $error("shift left with tms low");
   a_tms_leave: assert property (disable iff (!rst_n)
      tms |=> !tdo_oe) else $error("still shifting after tms high");
   a_five_ones: assert property (disable iff (!rst_n)
      tms [*5] |-> !tdo_oe ##1 !tdo_oe) else $error("tms reset failed");
endmodule
`default_nettype wire

// >>> testbench/jtdr_tester.sv
// tester model: drives tck, tms and tdi and reads tdo back
// assumes tdo is updated on falling tck; tck parks low between calls
`timescale 1ns/1ns
`default_nettype none
module jtdr_tester
(
   // tap pins
   output logic      tck,
   output logic      tms,
   output logic      tdi,
   input  wire logic tdo
);
   logic [39:0] dout;
   logic        so;
   event        done;
   initial {tck, tms, tdi} = 3'h0;
   // ----------------------------------------------------------------
   // one tck period; tdo is read just before the rising edge
   // ----------------------------------------------------------------
   task tick(input logic m, input logic d);
      #1 tms = m;
      tdi = d;
      #14 so = tdo;
      tck = 1'b1;
      #15 tck = 1'b0;
   endtask
   // idle tdi toggles so a stuck path cannot pass by luck
   task ones(input int n);
      repeat (n) tick(1'b1, ~tdi);
   endtask
   // scan from idle back to idle, lsb first
   task scan(input logic ir, input logic [39:0] din, input int n);
      ones(1 + ir);
      tick(1'b0, ~tdi);
      tick(1'b0, ~tdi);
      for (int i = 0; i < n; i++)
      begin
         tick(i == n - 1, din[i]);
         dout[i] = so;
      end
      ones(1);
      tick(1'b0, ~tdi);
      if (!ir)
         -> done;
   endtask
endmodule
`default_nettype wire

// >>> testbench/test_jtdr_top.sv
// bench for the test data registers; the tester model drives the tap
// assumes checker and tester files are compiled first
`timescale 1ns/1ns
`default_nettype none
module test_jtdr_top
   import jtdr_pkg::*;
;
   // id word fields: arbitrary values
   localparam logic [31:0] ID_WORD = 32'h3A5C3563;
   logic        core_clk, rst_n, tck, tms, tdi, tdo, tdo_oe;
   logic [3:0]  pin_in, drv_out;
   logic [1:0]  drv_oe, bidir_in;
   logic [39:0] q[$];
   int          mismatches, total_checks;
   // ----------------------------------------------------------------
   // clock, design and tester
   // ----------------------------------------------------------------
   initial
   begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   jtdr_top #(.ID_VER(ID_WORD[31:28]), .ID_PART(ID_WORD[27:12]),
      .ID_MFR(ID_WORD[11:1])) uut (.core_clk(core_clk), .rst_n(rst_n),
      .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
      .pin_in(pin_in), .drv_out(drv_out), .drv_oe(drv_oe),
      .bidir_in(bidir_in));
   jtdr_tester tester (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
   // ----------------------------------------------------------------
   // checking and verdict
   // ----------------------------------------------------------------
   task check(input logic [39:0] e, input logic [39:0] g);
      total_checks++;
      if (g !== e)
      begin
         mismatches++;
         $display("Error at %0t: expected %h got %h", $time, e, g);
      end
   endtask
   initial forever
      @(tester.done) check(q.pop_front(), tester.dout);
   task results;
      if (mismatches == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // tck must run while reset is low, the sync sits in the tck domain;
   // tms stays low, so only the power-on path can bring the tap back
   // to reset and to the id instruction
   task hw_reset;
      @(posedge core_clk) #2 rst_n = 1'b0;
      fork
         repeat (4) tester.tick(1'b0, ~tdi);
         repeat (6) @(posedge core_clk);
      join
      @(posedge core_clk) #2 rst_n = 1'b1;
      repeat (4) tester.tick(1'b0, ~tdi);
   endtask
   // 40-bit scan: captured word, then tdi delayed by the path length
   task dr(input int len, input logic [39:0] cap);
      logic [39:0] din;
      din = 40'({$urandom, $urandom});
      q.push_back((din << len) | cap);
      tester.scan(1'b0, din, 40);
   endtask
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      {rst_n, pin_in, drv_out, drv_oe, bidir_in} = 13'h0000;
      void'($urandom(38));
      hw_reset;
      dr(32, {8'h00, ID_WORD});
      for (int c = 0; c < 32; c++)
      begin
         @(posedge core_clk) #2 {pin_in, drv_out, drv_oe, bidir_in} =
            12'($urandom);
         tester.scan(1'b1, 40'(c), 5);
         if (c <= INSN_SAMPLE)
            dr(12, {28'h0, bidir_in, drv_oe, drv_out, pin_in});
         else if (c == INSN_IDCODE)
            dr(32, {8'h00, ID_WORD});
         else
            dr(1, 40'h0);
      end
      tester.ones(5);
      tester.tick(1'b0, ~tdi);
      dr(32, {8'h00, ID_WORD});
      tester.scan(1'b1, 40'h1F, 5);
      hw_reset;
      dr(32, {8'h00, ID_WORD});
      #100 results;
   end
   initial
   begin
      #1000000 mismatches++;
      results;
   end
endmodule
bind jtdr_top jtdr_checker chk (.rst_n(rst_n), .tck(tck), .tms(tms),
   .tdo(tdo), .tdo_oe(tdo_oe));
`default_nettype wire
